// *** sfxc_pkg.sv ***
package sfxc_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WRSR    = 8'h01;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_SPROG   = 8'h42;
  localparam logic [7:0] OP_SERASE  = 8'h44;
  localparam logic [7:0] OP_UID     = 8'h4b;
  localparam logic [7:0] OP_BE32    = 8'h52;
  localparam logic [7:0] OP_CE_A    = 8'h60;
  localparam logic [7:0] OP_PAUSE   = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_BOOST   = 8'ha3;
  localparam logic [7:0] OP_REL     = 8'hab;
  localparam logic [7:0] OP_PD      = 8'hb9;
  localparam logic [7:0] OP_DIO     = 8'hbb;
  localparam logic [7:0] OP_CE_B    = 8'hc7;
  localparam logic [7:0] OP_BE64    = 8'hd8;
  localparam logic [7:0] OP_QIOW    = 8'he7;
  localparam logic [7:0] OP_QIO     = 8'heb;
  localparam logic [7:0] OP_CREXIT  = 8'hff;
  localparam logic [7:0] OP_NONE    = 8'h00;
  // ****************************************
  // Frame layout in bytes, plus mode nibble and last bit index
  // ****************************************
  localparam logic [8:0] BOOST_BYTES = 9'h004;
  localparam logic [8:0] EXACT_BYTES = 9'h001;
  localparam logic [8:0] ADDR_BYTES  = 9'h004;
  localparam logic [8:0] DATA_FIRST  = 9'h004;
  localparam logic [8:0] UID_FIRST   = 9'h005;
  localparam logic [8:0] CR_MODE_IDX = 9'h004;
  localparam logic [8:0] CR_SKIP     = 9'h002;
  localparam logic [8:0] IDX_AHI     = 9'h001;
  localparam logic [8:0] IDX_AMID    = 9'h002;
  localparam logic [8:0] IDX_ALO     = 9'h003;
  localparam logic [3:0] CR_ACTIVE   = 4'ha;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  // ****************************************
  // Security registers and status bits
  // ****************************************
  localparam int         SEC_REGS  = 4;
  localparam int         SEC_BYTES = 256;
  localparam logic [7:0] SEC_TOP   = 8'h00;
  localparam logic [7:0] SEC_LAST  = 8'h03;
  localparam logic [7:0] ERASED    = 8'hff;
  localparam int SR_WIP   = 0;
  localparam int SR_WEL   = 1;
  localparam int SR_LOCK  = 2;
  localparam int SR_SUS   = 3;
  localparam int SR_BOOST = 4;
  // ****************************************
  // Timing at the 5 ns reference clock
  // ****************************************
  localparam int REF_PS     = 5000;
  localparam int RESUME_NS  = 200;
  localparam int RESUME_CYC = (RESUME_NS * 1000) / REF_PS;
  localparam int PAUSE_NS   = 20000;
  localparam int PAUSE_CYC  = (PAUSE_NS * 1000) / REF_PS;
endpackage

// *** sfxc_spi_if.sv ***
`timescale 1ns/100ps
interface sfxc_spi_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  modport dev  (input cs_n, input sclk, input si, output so);
  modport host (output cs_n, output sclk, output si, input so);
endinterface

// *** sfxc_buf2.sv ***
`timescale 1ns/100ps
module sfxc_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  logic [WIDTH-1:0] skid_d_ff;
  logic             skid_v_ff;

  // Output stage plus one skid word gives two entries with registered ready
  if (DEPTH != 2 || WIDTH < 1)
  begin : g_chk
    $error("sfxc_buf2 serves exactly two entries");
  end

  assign in_ready_out = ~skid_v_ff;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      skid_v_ff     <= 1'b0;
      skid_d_ff     <= '0;
    end
    else if (out_ready_in || !out_valid_out)
    begin
      out_valid_out <= skid_v_ff | in_valid_in;
      out_data_out  <= skid_v_ff ? skid_d_ff : in_data_in;
      skid_v_ff     <= 1'b0;
    end
    else if (in_valid_in && !skid_v_ff)
    begin
      skid_v_ff <= 1'b1;
      skid_d_ff <= in_data_in;
    end
endmodule

// *** sfxc_spi_host.sv ***
`timescale 1ns/100ps
module sfxc_spi_host #(
  parameter int HALF   = 6,
  parameter int CS_GAP = 8
) (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  sfxc_spi_if.host        spi,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_last_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic            busy_out
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_NEXT, H_GAP} sfxc_hst_t;
  sfxc_hst_t  st_ff;
  logic [8:0] txb_d;
  logic       txb_v;
  logic       txb_pop;
  logic       rxb_rdy;
  logic [7:0] sh_ff;
  logic [7:0] rx_ff;
  logic       last_ff;
  logic [2:0] bit_ff;
  logic [7:0] cnt_ff;
  logic       so_s1_ff;
  logic       so_s2_ff;

  if (HALF < 3 || HALF > 255 || CS_GAP < 4 || CS_GAP > 255)
  begin : g_chk
    $error("sfxc_spi_host: HALF 3..255, CS_GAP 4..255");
  end

  sfxc_buf2 #(.WIDTH(9), .DEPTH(2)) u_txb (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .in_data_in    ({tx_last_in, tx_data_in}),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (txb_d),
    .out_valid_out (txb_v),
    .out_ready_in  (txb_pop)
  );

  // A stalled reader holds the engine in H_NEXT, so no byte is dropped
  // Push only in the cycle the engine can leave, or a dry stream repeats the byte
  sfxc_buf2 #(.WIDTH(8), .DEPTH(2)) u_rxb (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .in_data_in    (rx_ff),
    .in_valid_in   (st_ff == H_NEXT && (last_ff || txb_v)),
    .in_ready_out  (rxb_rdy),
    .out_data_out  (rx_data_out),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );

  // Serial output changes while the link clock is low, well after the device edge
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      so_s1_ff <= 1'b0;
      so_s2_ff <= 1'b0;
    end
    else
    begin
      so_s1_ff <= spi.so;
      so_s2_ff <= so_s1_ff;
    end

  assign txb_pop = txb_v && ((st_ff == H_IDLE) || (st_ff == H_NEXT && rxb_rdy && !last_ff));

  // ****************************************
  // Byte engine
  // ****************************************
  // caller order
  // Boost entry before fast dual or quad reads is sequenced by the caller's stream
  // caller order
  // Write enable ahead of security commands also comes from the caller's stream
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      st_ff    <= H_IDLE;
      spi.cs_n <= 1'b1;
      spi.sclk <= 1'b0;
      spi.si   <= 1'b0;
      sh_ff    <= '0;
      rx_ff    <= '0;
      last_ff  <= 1'b0;
      bit_ff   <= '0;
      cnt_ff   <= '0;
      busy_out <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        H_IDLE:
          if (txb_v)
          begin
            spi.cs_n <= 1'b0;
            busy_out <= 1'b1;
            st_ff    <= H_LOW;
          end
        H_LOW:
          if (cnt_ff == 8'(HALF - 1))
          begin
            spi.sclk <= 1'b1;
            cnt_ff   <= '0;
            st_ff    <= H_HIGH;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        H_HIGH:
          if (cnt_ff == 8'(HALF - 1))
          begin
            spi.sclk <= 1'b0;
            cnt_ff   <= '0;
            rx_ff    <= {rx_ff[6:0], so_s2_ff};
            sh_ff    <= {sh_ff[6:0], 1'b0};
            spi.si   <= sh_ff[6];
            bit_ff   <= bit_ff + 3'h1;
            st_ff    <= (bit_ff == sfxc_pkg::LAST_BIT) ? H_NEXT : H_LOW;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        H_NEXT:
          if (rxb_rdy && last_ff)
          begin
            spi.cs_n <= 1'b1;
            st_ff    <= H_GAP;
          end
          else if (txb_pop)
            st_ff <= H_LOW;
        H_GAP:
          if (cnt_ff == 8'(CS_GAP - 1))
          begin
            cnt_ff   <= '0;
            busy_out <= 1'b0;
            st_ff    <= H_IDLE;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        default:
          st_ff <= H_IDLE;
      endcase
      if (txb_pop)
      begin
        sh_ff   <= txb_d[7:0];
        spi.si  <= txb_d[7];
        last_ff <= txb_d[8];
      end
    end
endmodule

// *** sfxc_flash_dev.sv ***
`timescale 1ns/100ps
// Overview of operation
// - Host sends boost command before fast I/O; the code decodes fast I/O and mode bits with boost off as well
// - Boost: opcode, three dummy bytes, select high
// - Release or power-down opcode leaves boost; the code exits boost only while no write cycle runs (st_ff R_IDLE)
// - Mode bits Ax: next read skips opcode
// - Continuous mode blocks decode; FF exits it
// - Unique ID: four dummies, 128 bits loop
// - Pause only during running program or erase
// - Pause flag at once, busy falls later
// - While paused, writes and erases are rejected
// - Resume only when paused and not busy
// - Resume clears pause, busy rises quickly
// - Four 256-byte security registers, one erase clears all four
// - Host sets write latch before security writes
// - Security erase needs exactly eight bits
// - Self-timed cycle starts at select rise
// - Lock flag ignores security erase, program
// - Program: opcode, address, 1..256 data bytes
// - Address top 00, middle 00..03, low byte
module sfxc_flash_dev #(
  parameter int            PROG_CYC   = 8000,
  parameter int            ERASE_CYC  = 20000,
  parameter int            SERASE_CYC = 20000,
  parameter int            CHIP_CYC   = 80000,
  // Arbitrary identifier value
  parameter logic [127:0]  UID        = 128'h5a5a_0123_4567_89ab_cdef_fedc_ba98_a5a5
) (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  sfxc_spi_if.dev         spi,
  input  wire logic       lock_set_in,
  input  wire logic [9:0] sec_addr_in,
  output logic [7:0]      sec_data_out,
  output logic            write_in_progress_flag_out,
  output logic            paused_status_flag_out,
  output logic            write_latch_flag_out,
  output logic            otp_lock_flag_out,
  output logic            boost_mode_out,
  output logic            continuous_read_out
);
  typedef enum logic [1:0] {R_IDLE, R_BUSY, R_PAUSING, R_PAUSED} sfxc_rst_t;
  typedef enum logic [1:0] {K_PROG, K_ERASE, K_CHIP, K_SEC} sfxc_kind_t;

  if (PROG_CYC < 2 || ERASE_CYC < 2 || SERASE_CYC < 2 || CHIP_CYC < 2
      || sfxc_pkg::RESUME_CYC < 4 || sfxc_pkg::PAUSE_CYC < 1)
  begin : g_chk
    $error("sfxc_flash_dev: cycle counts too small");
  end

  // ****************************************
  // Link side, on the host's serial clock
  // ****************************************
  logic [2:0]   bit_ff;
  logic [8:0]   byte_ff;
  logic [7:0]   sh_ff;
  logic [7:0]   op_ff;
  logic [8:0]   nb_ff;
  logic         part_ff;
  logic         seq_ff;
  logic         cont_ff;
  logic [7:0]   a_hi_ff;
  logic [7:0]   a_mid_ff;
  logic [7:0]   a_lo_ff;
  logic [255:0] pg_ok_ff;
  logic [7:0]   pg_mem [sfxc_pkg::SEC_BYTES];
  logic [4:0]   st_s1_ff;
  logic [4:0]   st_s2_ff;
  logic         so_ff;
  logic [7:0]   byte_now;
  logic         done;
  logic [8:0]   uid_byte;
  logic [6:0]   uid_idx;
  logic [7:0]   pg_idx;

  assign byte_now = {sh_ff[6:0], spi.si};
  assign done     = (bit_ff == sfxc_pkg::LAST_BIT);
  assign uid_byte = byte_ff - sfxc_pkg::UID_FIRST;
  assign uid_idx  = 7'h7f - {uid_byte[3:0], bit_ff};
  assign pg_idx   = a_lo_ff + byte_ff[7:0] - sfxc_pkg::DATA_FIRST[7:0];
  assign spi.so   = so_ff;
  assign continuous_read_out = cont_ff;

  always_ff @(posedge spi.sclk)
    sh_ff <= byte_now;

  // Counters restart with every frame; select high holds them clear
  always_ff @(posedge spi.sclk or posedge spi.cs_n)
    if (spi.cs_n)
    begin
      bit_ff  <= '0;
      byte_ff <= '0;
    end
    else
    begin
      bit_ff <= bit_ff + 3'h1;
      if (done && byte_ff == '0 && cont_ff && byte_now != sfxc_pkg::OP_CREXIT)
        byte_ff <= sfxc_pkg::CR_SKIP;
      else if (done)
        byte_ff <= byte_ff + 9'h001;
    end

  // Frame summary stays put after select rises, for the reference side
  always_ff @(posedge spi.sclk or negedge arst_n_in)
    if (!arst_n_in)
    begin
      op_ff    <= sfxc_pkg::OP_NONE;
      nb_ff    <= '0;
      part_ff  <= 1'b0;
      seq_ff   <= 1'b0;
      cont_ff  <= 1'b0;
      a_hi_ff  <= '0;
      a_mid_ff <= '0;
      a_lo_ff  <= '0;
      pg_ok_ff <= '0;
    end
    else
    begin
      part_ff <= !done;
      if (done)
        nb_ff <= byte_ff + 9'h001;
      if (done && byte_ff == '0)
      begin
        seq_ff <= ~seq_ff;
        if (!cont_ff)
          op_ff <= byte_now;
        else if (byte_now == sfxc_pkg::OP_CREXIT)
        begin
          op_ff   <= sfxc_pkg::OP_NONE;
          cont_ff <= 1'b0;
        end
        else
        begin
          op_ff   <= sfxc_pkg::OP_DIO;
          a_hi_ff <= byte_now;
        end
        if (!cont_ff && byte_now == sfxc_pkg::OP_SPROG)
          pg_ok_ff <= '0;
      end
      if (done && byte_ff == sfxc_pkg::IDX_AHI)
        a_hi_ff <= byte_now;
      if (done && byte_ff == sfxc_pkg::IDX_AMID)
        a_mid_ff <= byte_now;
      if (done && byte_ff == sfxc_pkg::IDX_ALO)
        a_lo_ff <= byte_now;
      if (done && byte_ff == sfxc_pkg::CR_MODE_IDX && (op_ff == sfxc_pkg::OP_DIO
          || op_ff == sfxc_pkg::OP_QIO || op_ff == sfxc_pkg::OP_QIOW))
        cont_ff <= (byte_now[7:4] == sfxc_pkg::CR_ACTIVE);
      if (done && op_ff == sfxc_pkg::OP_SPROG && byte_ff >= sfxc_pkg::DATA_FIRST)
        pg_ok_ff[pg_idx] <= 1'b1;
    end

  always_ff @(posedge spi.sclk)
    if (done && op_ff == sfxc_pkg::OP_SPROG && byte_ff >= sfxc_pkg::DATA_FIRST)
      pg_mem[pg_idx] <= byte_now;

  always_ff @(posedge spi.sclk or negedge arst_n_in)
    if (!arst_n_in)
    begin
      st_s1_ff <= '0;
      st_s2_ff <= '0;
    end
    else
    begin
      st_s1_ff <= {boost_mode_out, paused_status_flag_out, otp_lock_flag_out,
                   write_latch_flag_out, write_in_progress_flag_out};
      st_s2_ff <= st_s1_ff;
    end

  // Output bits change on the falling edge so the host samples a settled level
  always_ff @(negedge spi.sclk or posedge spi.cs_n or negedge arst_n_in)
    if (!arst_n_in || spi.cs_n)
      so_ff <= 1'b0;
    else if (op_ff == sfxc_pkg::OP_RDSR && byte_ff != '0)
      so_ff <= (bit_ff > 3'h2) ? st_s2_ff[3'h7 - bit_ff] : 1'b0;
    else if (op_ff == sfxc_pkg::OP_UID && byte_ff >= sfxc_pkg::UID_FIRST)
      so_ff <= UID[uid_idx];
    else
      so_ff <= 1'b0;

  // ****************************************
  // Reference side: frame end and timed cycles
  // ****************************************
  sfxc_rst_t  st_ff;
  sfxc_kind_t kind_ff;
  logic [31:0] tmr_ff;
  logic [31:0] pcnt_ff;
  logic        cs_s1_ff;
  logic        cs_s2_ff;
  logic        cs_s3_ff;
  logic        sq_s1_ff;
  logic        sq_s2_ff;
  logic        seen_ff;
  logic        evt;
  logic        exact;
  logic        whole;
  logic        can_write;
  logic        go;
  sfxc_kind_t  go_kind;
  logic [31:0] go_cyc;
  logic        go_sprog;
  logic        go_serase;
  localparam int SEC_REGS_TOTAL = sfxc_pkg::SEC_REGS * sfxc_pkg::SEC_BYTES;
  logic [7:0]  sec_mem [SEC_REGS_TOTAL];

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      sq_s1_ff <= 1'b0;
      sq_s2_ff <= 1'b0;
      seen_ff  <= 1'b0;
    end
    else
    begin
      cs_s1_ff <= spi.cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      sq_s1_ff <= seq_ff;
      sq_s2_ff <= sq_s1_ff;
      if (evt)
        seen_ff <= sq_s2_ff;
    end

  assign evt       = cs_s2_ff && !cs_s3_ff && (sq_s2_ff != seen_ff);
  assign exact     = (nb_ff == sfxc_pkg::EXACT_BYTES) && !part_ff;
  assign whole     = !part_ff;
  assign can_write = (st_ff == R_IDLE) && write_latch_flag_out;

  always_comb
  begin
    go        = 1'b0;
    go_kind   = K_PROG;
    go_cyc    = 32'(PROG_CYC);
    go_sprog  = 1'b0;
    go_serase = 1'b0;
    if (evt && can_write)
      unique case (op_ff)
        sfxc_pkg::OP_SERASE:
          go_serase = exact && !otp_lock_flag_out;
        sfxc_pkg::OP_SPROG:
          go_sprog = whole && nb_ff > sfxc_pkg::ADDR_BYTES && !otp_lock_flag_out
                     && a_hi_ff == sfxc_pkg::SEC_TOP && a_mid_ff <= sfxc_pkg::SEC_LAST;
        sfxc_pkg::OP_PP, sfxc_pkg::OP_QPP:
          go = whole && nb_ff > sfxc_pkg::ADDR_BYTES;
        sfxc_pkg::OP_SE, sfxc_pkg::OP_BE32, sfxc_pkg::OP_BE64:
        begin
          go      = whole && nb_ff == sfxc_pkg::ADDR_BYTES;
          go_kind = K_ERASE;
          go_cyc  = 32'(ERASE_CYC);
        end
        sfxc_pkg::OP_CE_A, sfxc_pkg::OP_CE_B:
        begin
          go      = exact;
          go_kind = K_CHIP;
          go_cyc  = 32'(CHIP_CYC);
        end
        default:
          go = 1'b0;
      endcase
    if (go_serase || go_sprog)
    begin
      go      = 1'b1;
      go_kind = K_SEC;
      go_cyc  = go_serase ? 32'(SERASE_CYC) : 32'(PROG_CYC);
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      st_ff   <= R_IDLE;
      kind_ff <= K_PROG;
      tmr_ff  <= '0;
      pcnt_ff <= '0;
    end
    else if (go)
    begin
      st_ff   <= R_BUSY;
      kind_ff <= go_kind;
      tmr_ff  <= go_cyc;
    end
    else if (evt && op_ff == sfxc_pkg::OP_PAUSE && exact && st_ff == R_BUSY
             && (kind_ff == K_PROG || kind_ff == K_ERASE))
    begin
      st_ff   <= R_PAUSING;
      pcnt_ff <= 32'(sfxc_pkg::PAUSE_CYC);
    end
    else if (evt && op_ff == sfxc_pkg::OP_RESUME && exact && st_ff == R_PAUSED)
      st_ff <= R_BUSY;
    else if (st_ff == R_BUSY)
    begin
      tmr_ff <= tmr_ff - 32'h1;
      if (tmr_ff <= 32'h1)
        st_ff <= R_IDLE;
    end
    else if (st_ff == R_PAUSING)
    begin
      pcnt_ff <= pcnt_ff - 32'h1;
      if (pcnt_ff <= 32'h1)
        st_ff <= R_PAUSED;
    end

  // Flags lag the state by one cycle so every output is a flip-flop
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      write_in_progress_flag_out <= 1'b0;
      paused_status_flag_out     <= 1'b0;
      write_latch_flag_out       <= 1'b0;
      otp_lock_flag_out          <= 1'b0;
      boost_mode_out             <= 1'b0;
    end
    else
    begin
      write_in_progress_flag_out <= (st_ff == R_BUSY) || (st_ff == R_PAUSING);
      paused_status_flag_out     <= (st_ff == R_PAUSING) || (st_ff == R_PAUSED);
      otp_lock_flag_out          <= otp_lock_flag_out | lock_set_in;
      // Latch drops as the cycle starts, ahead of completion
      if (go)
        write_latch_flag_out <= 1'b0;
      else if (evt && op_ff == sfxc_pkg::OP_WREN && exact
               && (st_ff == R_IDLE || st_ff == R_PAUSED))
        write_latch_flag_out <= 1'b1;
      if (evt && op_ff == sfxc_pkg::OP_BOOST && whole && nb_ff == sfxc_pkg::BOOST_BYTES)
        boost_mode_out <= 1'b1;
      else if (evt && st_ff == R_IDLE && whole
               && (op_ff == sfxc_pkg::OP_REL || (op_ff == sfxc_pkg::OP_PD && exact)))
        boost_mode_out <= 1'b0;
    end

  // four registers, erased together
  // Contents change as the cycle starts; the busy flag still covers the full time
  always_ff @(posedge ref_clk_in)
  begin
    for (int i = 0; i < SEC_REGS_TOTAL; i++)
      if (go_serase)
        sec_mem[i] <= sfxc_pkg::ERASED;
    for (int j = 0; j < sfxc_pkg::SEC_BYTES; j++)
      if (go_sprog && pg_ok_ff[j])
        sec_mem[{a_mid_ff[1:0], 8'(j)}] <= sec_mem[{a_mid_ff[1:0], 8'(j)}] & pg_mem[j];
    sec_data_out <= sec_mem[sec_addr_in];
  end
endmodule

// *** sfxc_asserts.sv ***
`timescale 1ns/100ps
module sfxc_asserts (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic write_in_progress_flag_out,
  input wire logic paused_status_flag_out,
  input wire logic otp_lock_flag_out,
  input wire logic boost_mode_out
);
  // ****
  // Link framing and flag timing
  // ****
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // The device needs a few reference cycles to see select high
  sequence s_gap;
    cs_n [*4];
  endsequence
  property p_gap;
    $rose(cs_n) |-> s_gap;
  endproperty
  property p_idle;
    cs_n |-> !sclk;
  endproperty
  // Boost moves one cycle ahead of the busy flag, three edges after select rises
  property p_boost_on;
    $rose(boost_mode_out) |-> cs_n && $past(cs_n, 3);
  endproperty
  property p_boost_off;
    $fell(boost_mode_out) |-> cs_n && $past(cs_n, 3);
  endproperty
  property p_wip_go;
    $rose(write_in_progress_flag_out) |-> cs_n && $past(cs_n, 4);
  endproperty
  property p_pause;
    $rose(paused_status_flag_out) |-> write_in_progress_flag_out;
  endproperty
  property p_resume;
    $fell(paused_status_flag_out) |-> $rose(write_in_progress_flag_out);
  endproperty
  property p_lock;
    otp_lock_flag_out |=> otp_lock_flag_out;
  endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  a_idle: assert property (p_idle) else $error("clock outside frame");
  a_boost_on: assert property (p_boost_on) else $error("boost early");
  a_boost_off: assert property (p_boost_off) else $error("boost exit early");
  a_wip_go: assert property (p_wip_go) else $error("cycle before select");
  a_pause: assert property (p_pause) else $error("pause while idle");
  a_resume: assert property (p_resume) else $error("resume not paired");
  a_lock: assert property (p_lock) else $error("lock cleared");
endmodule

// *** sfxc_tb.sv ***
`timescale 1ns/100ps
module sfxc_tb;
  // Arbitrary identifier value
  localparam logic [127:0] UID_V = 128'h0123456789abcdeffedcba9876543210;
  logic       ref_clk_in = 1'h0;
  logic       arst_n_in = 1'h1;
  logic       lock = 1'h0;
  logic       tl = 1'h0;
  logic       tv = 1'h0;
  logic       rr = 1'h1;
  logic [7:0] td = 8'h00;
  logic [7:0] lf = 8'h31;
  logic [9:0] sa = 10'h000;
  logic [7:0] rd, sd;
  logic       tr, rv, busy, write_in_progress_flag, paused_status_flag, write_latch_flag, lk, bst, crd;
  logic [7:0] rxq[$];
  int         err_total = 0;
  int         n_tests = 0;
  sfxc_spi_if spi_if ();
  sfxc_spi_host u_sfxc_spi_host (.ref_clk_in, .arst_n_in, .spi(spi_if.host),
    .tx_data_in(td), .tx_last_in(tl), .tx_valid_in(tv), .tx_ready_out(tr),
    .rx_data_out(rd), .rx_valid_out(rv), .rx_ready_in(rr), .busy_out(busy));
  sfxc_flash_dev #(.PROG_CYC(40), .ERASE_CYC(600), .SERASE_CYC(50), .UID(UID_V))
    u_sfxc_flash_dev (.ref_clk_in, .arst_n_in, .spi(spi_if.dev), .lock_set_in(lock),
    .sec_addr_in(sa), .sec_data_out(sd), .write_in_progress_flag_out(write_in_progress_flag),
    .paused_status_flag_out(paused_status_flag), .write_latch_flag_out(write_latch_flag), .otp_lock_flag_out(lk),
    .boost_mode_out(bst), .continuous_read_out(crd));
  sfxc_asserts u_sfxc_asserts (.ref_clk_in, .arst_n_in, .cs_n(spi_if.cs_n),
    .sclk(spi_if.sclk), .write_in_progress_flag_out(write_in_progress_flag),
    .paused_status_flag_out(paused_status_flag), .otp_lock_flag_out(lk), .boost_mode_out(bst));
  always #2.5 ref_clk_in = ~ref_clk_in;
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  function automatic logic [7:0] uid_b(input int i);
    return UID_V[127 - 8 * (i % 16) -: 8];
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkf(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  // Whole frame, then wait out the select gap so the flags have settled
  task automatic frame(input logic [7:0] b[$]);
    rxq.delete();
    foreach (b[i])
    begin
      td = b[i];
      tl = (i == b.size() - 1);
      tv = 1'h1;
      @(negedge ref_clk_in);
      while (!tr)
        @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      #1;
    end
    tv = 1'h0;
    for (int k = 0; k < 9000 && (busy || rxq.size() < b.size() || k < 8); k++)
      @(negedge ref_clk_in);
    if (busy || rxq.size() < b.size())
      err_total++;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wait_wip();
    for (int k = 0; k < 9000 && write_in_progress_flag; k++)
      @(negedge ref_clk_in);
    if (write_in_progress_flag)
      err_total++;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic rdsec(input logic [9:0] a, input logic [7:0] e);
    sa = a;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("secmem", e, sd);
  endtask
  // Falling-edge sampling sees what the next rising edge will take
  always @(negedge ref_clk_in)
    if (rv && rr)
      rxq.push_back(rd);
  // Random stalls exercise the two-entry buffer
  always @(posedge ref_clk_in)
    #1 rr = (rnd() > 8'h40);
  // ****
  // Scenarios
  // ****
  initial
  begin
    logic [7:0] q[$];
    logic [7:0] d[3];
    // A real falling edge, so every asynchronous reset branch runs
    #1 arst_n_in = 1'h0;
    repeat (2) @(posedge ref_clk_in);
    #1 arst_n_in = 1'h1;
    frame({8'ha3, rnd(), rnd(), rnd()});
    chkf("boost", 1'h1, bst);
    frame({8'h05, 8'h00});
    chk("status", 8'h10, rxq[1]);
    frame({8'hab});
    chkf("boost", 1'h0, bst);
    frame({8'ha3, rnd(), rnd(), rnd()});
    frame({8'hb9});
    chkf("boost", 1'h0, bst);
    frame({8'hab});
    q = {8'h4b};
    repeat (24) q.push_back(rnd());
    frame(q);
    for (int i = 0; i < 20; i++)
      chk("uid", uid_b(i), rxq[i + 5]);
    $display("test ids done");
    frame({8'hbb, 8'h00, 8'h10, 8'h00, 8'ha5});
    chkf("cont", 1'h1, crd);
    frame({8'h06});
    chkf("wel", 1'h0, write_latch_flag);
    frame({8'hff});
    chkf("cont", 1'h0, crd);
    frame({8'h06});
    chkf("wel", 1'h1, write_latch_flag);
    frame({8'h75});
    chkf("sus", 1'h0, paused_status_flag);
    frame({8'h7a});
    chkf("wip", 1'h0, write_in_progress_flag);
    $display("test modes done");
    frame({8'h44, 8'h00});
    chkf("wip", 1'h0, write_in_progress_flag);
    frame({8'h44});
    chkf("wip", 1'h1, write_in_progress_flag);
    chkf("wel", 1'h0, write_latch_flag);
    wait_wip();
    for (int r = 0; r < 4; r++)
      rdsec({r[1:0], rnd()}, 8'hff);
    d = '{rnd(), rnd(), rnd()};
    frame({8'h06});
    frame({8'h42, 8'h00, 8'h02, 8'hfe, d[0], d[1], d[2]});
    chkf("wip", 1'h1, write_in_progress_flag);
    wait_wip();
    rdsec(10'h2fe, d[0]);
    rdsec(10'h200, d[2]);
    rdsec(10'h300, 8'hff);
    frame({8'h06});
    frame({8'h42, 8'h01, 8'h00, 8'h00, 8'h00});
    chkf("wip", 1'h0, write_in_progress_flag);
    $display("test secure done");
    frame({8'h06});
    frame({8'h20, 8'h00, 8'h00, 8'h00});
    frame({8'h75});
    chkf("sus", 1'h1, paused_status_flag);
    chkf("wip", 1'h1, write_in_progress_flag);
    wait_wip();
    frame({8'h06});
    chkf("wel", 1'h1, write_latch_flag);
    frame({8'h44});
    chkf("wip", 1'h0, write_in_progress_flag);
    frame({8'h7a});
    chkf("sus", 1'h0, paused_status_flag);
    chkf("wip", 1'h1, write_in_progress_flag);
    wait_wip();
    $display("test pause done");
    lock = 1'h1;
    repeat (4) @(posedge ref_clk_in);
    #1 chkf("lock", 1'h1, lk);
    frame({8'h06});
    frame({8'h42, 8'h00, 8'h00, 8'h00, 8'h00});
    chkf("wip", 1'h0, write_in_progress_flag);
    $display("test lock done");
    finish_test();
  end
  initial
  begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule
